// file: hdl/mac_cfg_pkg.sv
// Constants and types for the external port configuration block
package mac_cfg_pkg;

  // ==========================================
  // Bus geometry and port numbering
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_PORTS = 7;
  localparam int unsigned NUM_EXT = 2;
  localparam logic [3:0] FIRST_PORT = 4'h1;
  localparam logic [3:0] FIRST_EXT_PORT = 4'h6;

  // ==========================================
  // Register offsets inside a port bank
  localparam logic [11:0] OFS_MEDIA_INDEPENDENT_PORT_A = 12'h300;
  localparam logic [11:0] OFS_MEDIA_INDEPENDENT_PORT_B = 12'h301;
  localparam logic [11:0] OFS_SMAC_A = 12'h400;
  localparam logic [11:0] OFS_SMAC_B = 12'h401;

  // ==========================================
  // Field positions
  localparam int unsigned XA_DUPLEX = 6;
  localparam int unsigned XA_TXFC = 5;
  localparam int unsigned XA_SPD100 = 4;
  localparam int unsigned XA_RXFC = 3;
  localparam int unsigned XB_GIG_N = 6;
  localparam int unsigned XB_RXDLY = 4;
  localparam int unsigned XB_TXDLY = 3;
  localparam int unsigned XB_ROLE = 2;
  localparam int unsigned XB_TYPE_HI = 1;
  localparam int unsigned XB_TYPE_LO = 0;
  localparam int unsigned SA_STORM = 1;
  localparam int unsigned SB_BP = 3;
  localparam int unsigned SB_PASS = 0;

  // ==========================================
  // Values after reset and writable masks
  localparam logic [7:0] XA_RST_FIRST = 8'h50;
  localparam logic [7:0] XA_RST_SECOND = 8'hD0;
  localparam logic [7:0] XB_RST = 8'h08;
  localparam logic [7:0] SA_RST = 8'h00;
  localparam logic [7:0] SB_RST = 8'h00;
  localparam logic [7:0] XA_WMASK = 8'h7F;
  localparam logic [7:0] XB_WMASK = 8'hFF;
  localparam logic [7:0] SA_WMASK = 8'h0B;
  localparam logic [7:0] SB_WMASK = 8'hBF;

  // ==========================================
  // Strap capture timing, in core cycles
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
  localparam logic [1:0] STRAP_DONE_CNT = 2'h3;

  // ==========================================
  // Enumerations
  typedef enum logic [1:0] {
    IF_RGMII = 2'b00,
    IF_RMII = 2'b01,
    IF_MII = 2'b10
  } if_mode_t;

  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10
  } speed_t;

  typedef enum logic [1:0] {
    FD_FORWARD = 2'b00,
    FD_DROP = 2'b01,
    FD_MIRROR = 2'b10
  } frame_disp_t;

endpackage

// file: hdl/sync_2ff.sv
// Two flip-flop level synchroniser, one per bit
`timescale 1ns/100ps
module sync_2ff #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // ==========================================
  // Both stages
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// file: hdl/mac_link_side.sv
// Link-clock logic of the media port: pause honour and frame disposition
`timescale 1ns/100ps
module mac_link_side (
  input wire logic i_link_clk,
  input wire logic i_rst_n,
  input wire logic i_full_duplex,
  input wire logic i_rx_fc_en,
  input wire logic i_pass_all,
  input wire logic i_storm_en,
  input wire logic i_fc_filter_en,
  input wire logic i_rx_pause,
  input wire logic i_frame_done,
  input wire logic i_frame_bad,
  input wire logic i_frame_flow_ctrl,
  input wire logic i_frame_broadcast,
  output logic o_tx_hold,
  output mac_cfg_pkg::frame_disp_t o_disp,
  output logic o_disp_valid,
  output logic o_storm_check
);
  import mac_cfg_pkg::*;

  // Configuration levels in the link domain
  logic [4:0] cfg_s;
  logic fd_s;
  logic rxfc_s;
  logic pass_s;
  logic storm_s;
  logic fcf_s;

  // ==========================================
  // Crossing of static configuration levels
  sync_2ff #(.W(5)) u_cfg_sync (
    .i_clk(i_link_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_full_duplex, i_rx_fc_en, i_pass_all, i_storm_en, i_fc_filter_en}),
    .o_q(cfg_s)
  );
  assign {fd_s, rxfc_s, pass_s, storm_s, fcf_s} = cfg_s;

  // ==========================================
  // Honour partner pause only when enabled
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_hold <= 1'b0;
    end else begin
      o_tx_hold <= i_rx_pause & rxfc_s & fd_s;
    end
  end

  // ==========================================
  // Frame disposition at end of each frame
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_disp <= FD_FORWARD;
      o_disp_valid <= 1'b0;
    end else begin
      o_disp_valid <= i_frame_done;
      if (i_frame_flow_ctrl) begin
        // Flow control frames ignore pass-all
        o_disp <= fcf_s ? FD_DROP : FD_FORWARD;
      end else if (i_frame_bad) begin
        // Bad frames dropped or mirrored only
        o_disp <= pass_s ? FD_MIRROR : FD_DROP;
      end else begin
        o_disp <= FD_FORWARD;
      end
    end
  end

  // ==========================================
  // Broadcast storm check request
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_storm_check <= 1'b0;
    end else begin
      o_storm_check <= i_frame_done & i_frame_broadcast & storm_s;
    end
  end
endmodule

// file: hdl/mac_port_interface_config.sv
// Per-port media interface and switch MAC configuration registers
//
// Notes on behaviour
// - Duplex bit set means full duplex
// - Send flow control only when enabled
// - Honour received pause only when enabled
// - Speed bit picks 100 or 10
// - Gigabit bit zero forces 1000 Mb/s
// - Receive clock delay selectable, resets off
// - Transmit clock delay selectable, resets on
// - MII role: MAC takes, PHY drives clocks
// - RMII reference clock taken or driven
// - Type code: RGMII, RMII, else MII
// - Flow control defaults come from strap
// - Storm protection for ingress broadcast
// - Back pressure only in half duplex
// - Bad frames dropped or mirrored, but forwarded if flow control with filtering off
// - Pass-all leaves flow control filtering
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module mac_port_interface_config (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  // Register port
  input wire logic [mac_cfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [mac_cfg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [mac_cfg_pkg::DATA_W-1:0] o_rdata,
  // Configuration strap pins
  input wire logic i_strap_gigabit_select,
  input wire logic i_strap_role_select,
  input wire logic [1:0] i_strap_interface_type,
  input wire logic i_strap_flow_control_default,
  // Core-side congestion per external port
  input wire logic [mac_cfg_pkg::NUM_EXT-1:0] i_congested,
  input wire logic [mac_cfg_pkg::NUM_EXT-1:0] i_rate_limit_fc,
  input wire logic i_fc_filter_en,
  // Link-side frame events of the media port
  input wire logic i_link_rx_pause,
  input wire logic i_link_frame_done,
  input wire logic i_link_frame_bad,
  input wire logic i_link_frame_flow_ctrl,
  input wire logic i_link_frame_broadcast,
  // Core-side port configuration
  output logic [mac_cfg_pkg::NUM_EXT-1:0] o_full_duplex,
  output mac_cfg_pkg::speed_t o_speed_first,
  output mac_cfg_pkg::speed_t o_speed_second,
  output logic [mac_cfg_pkg::NUM_EXT-1:0] o_pause_tx_req,
  output logic [mac_cfg_pkg::NUM_EXT-1:0] o_backpressure,
  output mac_cfg_pkg::if_mode_t o_if_mode,
  output logic o_mii_clocks_drive,
  output logic o_reduced_mii_ref_clock_drive,
  output logic o_rx_clock_internal_delay,
  output logic o_tx_clock_internal_delay,
  output logic [mac_cfg_pkg::NUM_PORTS-1:0] o_storm_protect,
  // Link-side results
  output logic o_link_tx_hold,
  output mac_cfg_pkg::frame_disp_t o_link_disp,
  output logic o_link_disp_valid,
  output logic o_link_storm_check
);
  import mac_cfg_pkg::*;

  // ==========================================
  // Declarations

  // Register storage, one entry per port, media banks for the external ports only
  logic [7:0] xa_q [NUM_EXT];
  logic [7:0] xb_q [NUM_EXT];
  logic [7:0] sa_q [NUM_PORTS];
  logic [7:0] sb_q [NUM_PORTS];

  // Address split into port and offset
  logic [3:0] port_num;
  logic [11:0] ofs;

  // Read data before the output flop
  logic [7:0] rdata_d;

  // Synchronised strap pins
  logic [4:0] strap_s;
  logic strap_gig;
  logic strap_role;
  logic [1:0] strap_type;
  logic strap_fc;

  // Strap capture sequencing
  logic [1:0] strap_cnt_q;
  logic strap_load;

  // Decoded media mode of the first port
  if_mode_t mode_d;

  // Speed per external port
  speed_t speed_d [NUM_EXT];

  // ==========================================
  // Address decode
  assign port_num = i_addr[15:12];
  assign ofs = i_addr[11:0];

  // ==========================================
  // Strap pins pass two flops first
  sync_2ff #(.W(5)) u_strap_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_strap_gigabit_select, i_strap_role_select,
          i_strap_interface_type, i_strap_flow_control_default}),
    .o_q(strap_s)
  );
  assign {strap_gig, strap_role, strap_type, strap_fc} = strap_s;

  // ==========================================
  // Count settle cycles after reset release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != STRAP_DONE_CNT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // One-cycle load once the pins have settled
  assign strap_load = (strap_cnt_q == STRAP_LOAD_CNT);

  // ==========================================
  // Switch MAC control banks, ports one to seven
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_smac
      // Bank hit for this port
      logic hit;
      assign hit = (port_num == FIRST_PORT + 4'(p));

      // Control A: storm enable and spare bits
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sa_q[p] <= SA_RST;
        end else if (i_wr && hit && ofs == OFS_SMAC_A) begin
          sa_q[p] <= i_wdata & SA_WMASK;
        end
      end

      // Control B: back pressure and pass-all
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sb_q[p] <= SB_RST;
        end else if (i_wr && hit && ofs == OFS_SMAC_B) begin
          sb_q[p] <= i_wdata & SB_WMASK;
        end
      end

      // Storm protection level per port
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_storm_protect[p] <= 1'b0;
        end else begin
          o_storm_protect[p] <= sa_q[p][SA_STORM];
        end
      end
    end
  endgenerate

  // ==========================================
  // Media port control banks, external ports
  generate
    for (genvar e = 0; e < NUM_EXT; e++) begin : g_media_independent_port
      // Bank hit for this external port
      logic hit;
      // Index into the MAC banks
      localparam int unsigned MI = int'(FIRST_EXT_PORT) - 1 + e;
      assign hit = (port_num == FIRST_EXT_PORT + 4'(e));

      // Control A: duplex, speed, flow control
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          xa_q[e] <= (e == 0) ? XA_RST_FIRST : XA_RST_SECOND;
        end else begin
          if (i_wr && hit && ofs == OFS_MEDIA_INDEPENDENT_PORT_A) begin
            // Top bit is read-only
            xa_q[e] <= (i_wdata & XA_WMASK) | (xa_q[e] & ~XA_WMASK);
          end
          if (strap_load) begin
            xa_q[e][XA_TXFC] <= strap_fc;
            xa_q[e][XA_RXFC] <= strap_fc;
          end
        end
      end

      // Control B: gigabit, delays, role, type
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          xb_q[e] <= XB_RST;
        end else begin
          if (i_wr && hit && ofs == OFS_MEDIA_INDEPENDENT_PORT_B) begin
            xb_q[e] <= i_wdata & XB_WMASK;
          end
          if (strap_load && e == 0) begin
            // Only the first port takes these straps
            xb_q[e][XB_GIG_N] <= strap_gig;
            xb_q[e][XB_ROLE] <= strap_role;
            xb_q[e][XB_TYPE_HI:XB_TYPE_LO] <= strap_type;
          end
        end
      end

      // Speed selection
      always_comb begin
        if (!xb_q[e][XB_GIG_N]) begin
          speed_d[e] = SPD_1000;
        end else if (xa_q[e][XA_SPD100]) begin
          speed_d[e] = SPD_100;
        end else begin
          speed_d[e] = SPD_10;
        end
      end

      // Duplex and congestion responses
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_full_duplex[e] <= 1'b1;
          o_pause_tx_req[e] <= 1'b0;
          o_backpressure[e] <= 1'b0;
        end else begin
          o_full_duplex[e] <= xa_q[e][XA_DUPLEX];
          // Pause only with transmit flow control on
          o_pause_tx_req[e] <= (i_congested[e] | i_rate_limit_fc[e])
                               & xa_q[e][XA_TXFC] & xa_q[e][XA_DUPLEX];
          // Jamming only in half duplex
          o_backpressure[e] <= i_congested[e] & sb_q[MI][SB_BP]
                               & ~xa_q[e][XA_DUPLEX];
        end
      end
    end
  endgenerate

  // ==========================================
  // Speed outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_speed_first <= SPD_100;
      o_speed_second <= SPD_1000;
    end else begin
      o_speed_first <= speed_d[0];
      o_speed_second <= speed_d[1];
    end
  end

  // ==========================================
  // Interface type decode, upper codes both MII
  always_comb begin
    if (xb_q[0][XB_TYPE_HI]) begin
      mode_d = IF_MII;
    end else if (xb_q[0][XB_TYPE_LO]) begin
      mode_d = IF_RMII;
    end else begin
      mode_d = IF_RGMII;
    end
  end

  // ==========================================
  // Pin direction and clock delay selection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_if_mode <= IF_RGMII;
      o_mii_clocks_drive <= 1'b0;
      o_reduced_mii_ref_clock_drive <= 1'b0;
      o_rx_clock_internal_delay <= 1'b0;
      o_tx_clock_internal_delay <= 1'b0;
    end else begin
      o_if_mode <= mode_d;
      // PHY role drives the MII clocks
      o_mii_clocks_drive <= (mode_d == IF_MII) & ~xb_q[0][XB_ROLE];
      // Role clear sources the reference clock
      o_reduced_mii_ref_clock_drive <= (mode_d == IF_RMII)
                                       & ~xb_q[0][XB_ROLE];
      // Delays apply to the RGMII clocks only
      o_rx_clock_internal_delay <= (mode_d == IF_RGMII)
                                   & xb_q[0][XB_RXDLY];
      o_tx_clock_internal_delay <= (mode_d == IF_RGMII)
                                   & xb_q[0][XB_TXDLY];
    end
  end

  // ==========================================
  // Read multiplexer, unmapped reads give zero
  always_comb begin
    rdata_d = 8'h00;
    for (int p = 0; p < int'(NUM_PORTS); p++) begin
      if (port_num == FIRST_PORT + 4'(p)) begin
        if (ofs == OFS_SMAC_A) begin
          rdata_d = sa_q[p];
        end
        if (ofs == OFS_SMAC_B) begin
          rdata_d = sb_q[p];
        end
      end
    end
    for (int e = 0; e < int'(NUM_EXT); e++) begin
      if (port_num == FIRST_EXT_PORT + 4'(e)) begin
        if (ofs == OFS_MEDIA_INDEPENDENT_PORT_A) begin
          rdata_d = xa_q[e];
        end
        if (ofs == OFS_MEDIA_INDEPENDENT_PORT_B) begin
          rdata_d = xb_q[e];
        end
      end
    end
  end

  // ==========================================
  // Read data valid only the cycle after a read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ==========================================
  // Link-domain logic of the first port
  mac_link_side u_link (
    .i_link_clk(i_link_clk),
    .i_rst_n(i_rst_n),
    .i_full_duplex(o_full_duplex[0]),
    .i_rx_fc_en(xa_q[0][XA_RXFC]),
    .i_pass_all(sb_q[int'(FIRST_EXT_PORT) - 1][SB_PASS]),
    .i_storm_en(o_storm_protect[int'(FIRST_EXT_PORT) - 1]),
    .i_fc_filter_en(i_fc_filter_en),
    .i_rx_pause(i_link_rx_pause),
    .i_frame_done(i_link_frame_done),
    .i_frame_bad(i_link_frame_bad),
    .i_frame_flow_ctrl(i_link_frame_flow_ctrl),
    .i_frame_broadcast(i_link_frame_broadcast),
    .o_tx_hold(o_link_tx_hold),
    .o_disp(o_link_disp),
    .o_disp_valid(o_link_disp_valid),
    .o_storm_check(o_link_storm_check)
  );

endmodule

// file: test/mac_port_interface_config_props.sv
// Concurrent checks on the configuration block's ports
`timescale 1ns/100ps
module mac_port_interface_config_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] i_congested,
  input wire logic [1:0] i_rate_limit_fc,
  input wire logic [1:0] o_full_duplex,
  input wire logic [1:0] o_pause_tx_req,
  input wire logic [1:0] o_backpressure,
  input wire mac_cfg_pkg::if_mode_t o_if_mode,
  input wire logic o_mii_clocks_drive,
  input wire logic o_reduced_mii_ref_clock_drive,
  input wire logic o_rx_clock_internal_delay,
  input wire logic o_tx_clock_internal_delay,
  input wire logic i_link_rx_pause,
  input wire logic i_link_frame_done,
  input wire logic i_link_frame_bad,
  input wire logic i_link_frame_flow_ctrl,
  input wire logic i_link_frame_broadcast,
  input wire logic o_link_tx_hold,
  input wire mac_cfg_pkg::frame_disp_t o_link_disp,
  input wire logic o_link_disp_valid,
  input wire logic o_link_storm_check
);
  import mac_cfg_pkg::*;

  // ==========
  // Core clock domain
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
  a_pause_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_pause_tx_req[0] |-> o_full_duplex[0] && $past(i_congested[0] | i_rate_limit_fc[0]))
    else $error("stray pause");
  a_bp_half_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_backpressure[0] |-> !o_full_duplex[0] && $past(i_congested[0]))
    else $error("bp in full duplex");
  a_rx_delay_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_rx_clock_internal_delay |-> o_if_mode == IF_RGMII) else $error("rx delay outside rgmii");
  a_tx_delay_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_tx_clock_internal_delay |-> o_if_mode == IF_RGMII) else $error("tx delay outside rgmii");
  a_mii_drive_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_mii_clocks_drive |-> o_if_mode == IF_MII) else $error("mii drive outside mii");
  a_ref_drive_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_reduced_mii_ref_clock_drive |-> o_if_mode == IF_RMII) else $error("ref drive outside rmii");
  a_mode_code_legal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_if_mode != 2'b11) else $error("illegal mode code");

  // ==========
  // Link clock domain
  a_hold_cause: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    o_link_tx_hold |-> $past(i_link_rx_pause)) else $error("tx hold without pause");
  a_bad_not_fwd: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    $past(i_link_frame_done && i_link_frame_bad && !i_link_frame_flow_ctrl)
    |-> o_link_disp_valid && o_link_disp != FD_FORWARD) else $error("bad frame forwarded");
  a_good_fwd: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    $past(i_link_frame_done && !i_link_frame_bad && !i_link_frame_flow_ctrl)
    |-> o_link_disp_valid && o_link_disp == FD_FORWARD) else $error("good frame not forwarded");
  a_storm_cause: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    o_link_storm_check |-> $past(i_link_frame_done && i_link_frame_broadcast))
    else $error("stray storm check");
endmodule

bind mac_port_interface_config mac_port_interface_config_props i_props (.*);

// file: test/mac_link_partner.sv
// Far-side link partner: frame events and pause level on the link clock
`timescale 1ns/100ps
module mac_link_partner (
  input wire logic i_link_clk,
  input wire logic i_disp_valid,
  input wire mac_cfg_pkg::frame_disp_t i_disp,
  input wire logic i_storm_check,
  output logic o_rx_pause,
  output logic o_frame_done,
  output logic o_frame_bad,
  output logic o_frame_flow_ctrl,
  output logic o_frame_broadcast
);
  import mac_cfg_pkg::*;
  logic busy; // High while a frame is being handed over

  // ==========
  // Idle qualifiers toggle so stale values never look valid
  initial begin
    {busy, o_rx_pause, o_frame_done} = 3'h0;
    {o_frame_bad, o_frame_flow_ctrl, o_frame_broadcast} = 3'h2;
  end
  always @(posedge i_link_clk) begin
    if (!busy) begin
      {o_frame_bad, o_frame_flow_ctrl, o_frame_broadcast} <=
        ~{o_frame_bad, o_frame_flow_ctrl, o_frame_broadcast};
    end
  end

  // ==========
  // Pause level as seen from the wire
  task automatic set_pause(input logic v);
    @(posedge i_link_clk);
    o_rx_pause <= v;
  endtask

  // One frame end event, then capture the block's verdict
  task automatic send_frame(input logic bad, fc, bc, output logic vld,
                            output frame_disp_t disp, output logic st);
    busy = 1'b1;
    @(posedge i_link_clk);
    o_frame_done <= 1'b1;
    o_frame_bad <= bad;
    o_frame_flow_ctrl <= fc;
    o_frame_broadcast <= bc;
    @(posedge i_link_clk);
    o_frame_done <= 1'b0;
    #1;
    vld = i_disp_valid;
    disp = i_disp;
    st = i_storm_check;
    busy = 1'b0;
  endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the port configuration block
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  import mac_cfg_pkg::*;
  logic i_clk, i_link_clk, i_rst_n, i_wr, i_rd, i_fc_filter_en;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [1:0] i_congested, i_rate_limit_fc, o_full_duplex, o_pause_tx_req, o_backpressure;
  logic i_link_rx_pause, i_link_frame_done, i_link_frame_bad, i_link_frame_flow_ctrl;
  logic i_link_frame_broadcast, o_mii_clocks_drive, o_reduced_mii_ref_clock_drive;
  logic o_rx_clock_internal_delay, o_tx_clock_internal_delay, o_link_tx_hold, strap_fc;
  logic o_link_disp_valid, o_link_storm_check;
  logic [6:0] o_storm_protect;
  speed_t o_speed_first, o_speed_second;
  if_mode_t o_if_mode;
  frame_disp_t o_link_disp;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  mac_port_interface_config i_mac_port_interface_config (.i_strap_gigabit_select(1'b1),
    .i_strap_role_select(1'b0), .i_strap_interface_type(2'b00),
    .i_strap_flow_control_default(strap_fc), .*);
  mac_link_partner i_mac_link_partner (.i_link_clk(i_link_clk), .i_disp(o_link_disp),
    .i_disp_valid(o_link_disp_valid), .i_storm_check(o_link_storm_check),
    .o_rx_pause(i_link_rx_pause), .o_frame_done(i_link_frame_done),
    .o_frame_bad(i_link_frame_bad), .o_frame_flow_ctrl(i_link_frame_flow_ctrl),
    .o_frame_broadcast(i_link_frame_broadcast));

  // ==========
  // Clocks, core 8 ns and link 80 ns at an odd phase
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #13;
    forever #40 i_link_clk = ~i_link_clk;
  end
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ==========
  // Register bus and timing helpers
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, exp)
  endtask
  task automatic hold2;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic settle;
    repeat (8) @(posedge i_link_clk);
    #1;
  endtask
  task automatic cg(input logic [1:0] c, input logic [1:0] r);
    @(posedge i_clk);
    i_congested <= c;
    i_rate_limit_fc <= r;
    hold2();
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    rd(16'h6300, 8'h78);
    rd(16'h7300, 8'hF8);
    rd(16'h6301, 8'h48);
    rd(16'h7301, 8'h08);
    rd(16'h3400, 8'h00);
    `CHK(o_full_duplex, 2'b11)
    `CHK(o_speed_first, SPD_100)
    `CHK(o_speed_second, SPD_1000)
    `CHK(o_if_mode, IF_RGMII)
    `CHK({o_tx_clock_internal_delay, o_rx_clock_internal_delay}, 2'b10)
  endtask
  task automatic t_regs;
    wr(16'h6300, 8'hFF);
    rd(16'h6300, 8'h7F);
    wr(16'h1400, 8'hFF);
    rd(16'h1400, 8'h0B);
    `CHK(o_storm_protect[0], 1'b1)
    wr(16'h1401, 8'hFF);
    rd(16'h1401, 8'hBF);
    wr(16'h1300, 8'h55);
    rd(16'h1300, 8'h00);
    rd(16'h6302, 8'h00);
    rd(16'h0400, 8'h00);
  endtask
  task automatic t_modes;
    if_mode_t m;
    for (int t = 0; t < 4; t++) begin
      for (int r = 0; r < 2; r++) begin
        wr(16'h6301, 8'h58 | (8'(r) << 2) | 8'(t));
        hold2();
        m = (t == 0) ? IF_RGMII : ((t == 1) ? IF_RMII : IF_MII);
        `CHK(o_if_mode, m)
        `CHK(o_mii_clocks_drive, (m == IF_MII) && (r == 0))
        `CHK(o_reduced_mii_ref_clock_drive, (m == IF_RMII) && (r == 0))
        `CHK({o_rx_clock_internal_delay, o_tx_clock_internal_delay},
             {2{m == IF_RGMII}})
      end
    end
  endtask
  task automatic t_speed;
    for (int g = 0; g < 2; g++) begin
      for (int s = 0; s < 2; s++) begin
        wr(16'h6301, 8'(g) << 6);
        wr(16'h6300, 8'h40 | (8'(s) << 4));
        hold2();
        `CHK(o_speed_first, g == 0 ? SPD_1000 : (s == 1 ? SPD_100 : SPD_10))
      end
    end
    wr(16'h7301, 8'h40);
    wr(16'h7300, 8'h40);
    hold2();
    `CHK(o_speed_second, SPD_10)
  endtask
  task automatic t_flow;
    wr(16'h6300, 8'h60);
    cg(2'b01, 2'b00);
    `CHK(o_pause_tx_req, 2'b01)
    cg(2'b00, 2'b01);
    `CHK(o_pause_tx_req, 2'b01)
    wr(16'h6300, 8'h40);
    hold2();
    `CHK(o_pause_tx_req, 2'b00)
    wr(16'h6401, 8'h08);
    wr(16'h6300, 8'h20);
    cg(2'b01, 2'b00);
    `CHK({o_full_duplex, o_backpressure, o_pause_tx_req}, 6'h24)
    wr(16'h6300, 8'h40);
    hold2();
    `CHK(o_backpressure, 2'b00)
    cg(2'b00, 2'b00);
  endtask
  task automatic lcase(input logic pass, filt, bad, fc, bc, input frame_disp_t exp,
                       input logic st_exp);
    logic v, st;
    frame_disp_t d;
    wr(16'h6401, {7'h00, pass});
    @(posedge i_clk);
    i_fc_filter_en <= filt;
    settle();
    i_mac_link_partner.send_frame(bad, fc, bc, v, d, st);
    `CHK({v, d, st}, {1'b1, exp, st_exp})
  endtask
  task automatic t_link;
    wr(16'h6300, 8'h48);
    wr(16'h6400, 8'h02);
    i_mac_link_partner.set_pause(1'b1);
    settle();
    `CHK({o_link_tx_hold, o_storm_protect[5]}, 2'b11)
    wr(16'h6300, 8'h40);
    settle();
    `CHK(o_link_tx_hold, 1'b0)
    i_mac_link_partner.set_pause(1'b0);
    lcase(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, FD_DROP, 1'b0);
    lcase(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, FD_MIRROR, 1'b0);
    lcase(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, FD_DROP, 1'b0);
    lcase(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, FD_FORWARD, 1'b0);
    lcase(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, FD_FORWARD, 1'b1);
    wr(16'h6400, 8'h00);
    lcase(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, FD_FORWARD, 1'b0);
  endtask
  // Mid-run reset with the flow control strap low
  task automatic t_strap;
    {i_rst_n, strap_fc} <= 2'h0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(16'h6300, 8'h50);
    rd(16'h7300, 8'hD0);
  endtask

  // ==========
  // Verdict
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {i_rst_n, i_wr, i_rd, i_fc_filter_en, strap_fc} = 5'h01;
    {i_addr, i_wdata, i_congested, i_rate_limit_fc} = 28'h0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_regs();
    t_modes();
    t_speed();
    t_flow();
    t_link();
    t_strap();
    tally_and_finish();
  end
endmodule
